// ---- hw/iwd_pkg.sv ----
// Shared constants, types and helpers of the independent watchdog.
package iwd_pkg;

   // Register byte offsets.
   localparam logic [4:0]  OFF_KEY        = 5'h00;
   localparam logic [4:0]  OFF_DIV        = 5'h04;
   localparam logic [4:0]  OFF_RLD        = 5'h08;
   localparam logic [4:0]  OFF_UPD        = 5'h0C;
   localparam logic [4:0]  OFF_EVT        = 5'h10;
   localparam logic [4:0]  OFF_MSK        = 5'h14;
   localparam logic [4:0]  OFF_CNT        = 5'h18;

   // Command keys.
   localparam logic [15:0] KEY_UNLOCK     = 16'h5555;
   localparam logic [15:0] KEY_START      = 16'hCCCC;
   localparam logic [15:0] KEY_RELOAD     = 16'hAAAA;

   // Field widths and reset values.
   localparam int          DIV_W          = 3;
   localparam int          RLD_W          = 12;
   localparam int          PRE_W          = 8;
   localparam int          EVT_W          = 3;
   localparam logic [2:0]  DIV_RST        = 3'h0;
   localparam logic [11:0] RLD_RST        = 12'hFFF;
   localparam logic [2:0]  EVT_RST        = 3'h0;
   localparam logic [2:0]  MSK_RST        = 3'h0;

   // Bit positions of the status fields.
   localparam int          UPD_DIV_BIT    = 0;
   localparam int          UPD_RLD_BIT    = 1;
   localparam int          EVT_EXP_BIT    = 0;
   localparam int          EVT_DIV_BIT    = 1;
   localparam int          EVT_RLD_BIT    = 2;

   // Oscillator ticks that a new setting needs to reach the counter.
   localparam logic [1:0]  UPD_TICKS      = 2'h3;

   typedef enum logic [1:0] {IWD_STOPPED, IWD_RUNNING, IWD_EXPIRED} iwd_state_t;

   // Last prescaler count for a divider selection; codes above 6 saturate at 256.
   function automatic logic [7:0] iwd_div_last(input logic [2:0] sel);
      logic [8:0] d;
      d = (sel > 3'h6) ? 9'h100 : (9'h004 << sel);
      return 8'(d - 9'h001);
   endfunction : iwd_div_last

   // Merge write data into a word by byte enables.
   function automatic logic [31:0] iwd_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : iwd_merge

endpackage : iwd_pkg

// ---- hw/iwd_core_if.sv ----
// Signals between the register front end and the watchdog counter.
`timescale 1ns/1ps
interface iwd_core_if;
   logic                     tick;
   logic                     start;
   logic                     reload;
   logic                     freeze;
   logic [iwd_pkg::DIV_W-1:0] div_sel;
   logic [iwd_pkg::RLD_W-1:0] rld_val;
   logic [iwd_pkg::RLD_W-1:0] count;
   logic                     running;
   logic                     expired;

   modport ctrl (output tick, start, reload, freeze, div_sel, rld_val,
                 input  count, running, expired);
   modport core (input  tick, start, reload, freeze, div_sel, rld_val,
                 output count, running, expired);
endinterface : iwd_core_if

// ---- hw/iwd_core.sv ----
// Prescaler and 12-bit down counter of the independent watchdog.
`timescale 1ns/1ps
module iwd_core (
   // Clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // Front end
   iwd_core_if.core   cif
);
   iwd_pkg::iwd_state_t        state_q;
   logic [iwd_pkg::PRE_W-1:0]  pre_q;
   logic [iwd_pkg::RLD_W-1:0]  cnt_q;
   logic                       step;

   assign step        = (state_q == iwd_pkg::IWD_RUNNING) & cif.tick & ~cif.freeze; // see R14
   assign cif.count   = cnt_q;
   assign cif.running = (state_q == iwd_pkg::IWD_RUNNING);
   assign cif.expired = (state_q == iwd_pkg::IWD_EXPIRED);

   // No software path leads back to the stopped state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= iwd_pkg::IWD_STOPPED;
      end else begin
         case (state_q)
            iwd_pkg::IWD_STOPPED: if (cif.start) state_q <= iwd_pkg::IWD_RUNNING; // see R2
            iwd_pkg::IWD_RUNNING: if (cnt_q == '0) state_q <= iwd_pkg::IWD_EXPIRED; // see R2, R16
            iwd_pkg::IWD_EXPIRED: state_q <= iwd_pkg::IWD_EXPIRED;
            default:              state_q <= iwd_pkg::IWD_STOPPED;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= '0;
         cnt_q <= iwd_pkg::RLD_RST;
      end else if (cif.reload || (cif.start && state_q == iwd_pkg::IWD_STOPPED)) begin
         pre_q <= '0;
         cnt_q <= cif.rld_val; // see R3
      end else if (step) begin
         if (pre_q >= iwd_pkg::iwd_div_last(cif.div_sel)) begin // see R4, R13
            pre_q <= '0;
            if (cnt_q != '0) begin
               cnt_q <= cnt_q - 12'h001;
            end
         end else begin
            pre_q <= pre_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_fire_on_zero: assert property (cif.running && cnt_q == '0 |=> cif.expired) // see R2
      else $error("Counter at zero did not expire");
   a_reload_value: assert property (cif.reload |=> cnt_q == $past(cif.rld_val)) // see R3
      else $error("Reload key did not load the reload value");
   a_freeze_hold: assert property (cif.running && cif.freeze && !cif.reload // see R14
                                   |=> $stable(cnt_q))
      else $error("Counter moved while frozen");
   c_expire: cover property (cif.running ##1 cif.expired);
endmodule : iwd_core

// ---- hw/iwd_regs.sv ----
// Wishbone register front end and top of the independent watchdog.
`timescale 1ns/1ps
// Summary of operation
// R1 - Key 0x5555 unlocks divider and reload registers
// R2 - Key 0xCCCC starts counter; zero gives reset
// R3 - Key 0xAAAA reloads counter from reload field
// R4 - Divider code selects 4 to 256 division
// R5 - Locked divider or reload writes are ignored
// R6 - Status bit 0 shows divider update pending
// R7 - Status bit 1 shows reload update pending
// R8 - Reload field 12 bits, resets to 0xFFF
// R9 - Software waits on pending flag between updates
// R10 - Software waits on divider flag before sleep
// R11 - Half-word and word accesses; reserved write zero
// R12 - Any other key restores write protection
// R13 - Eight-stage prescaler feeds 12-bit down counter
// R14 - Debug hold with halted core freezes counter
// R15 - Auto-start option starts counter after reset
// R16 - Running counter cannot be stopped by software
module iwd_regs (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [4:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   // Low-speed oscillator pin
   input  wire logic         low_speed_oscillator_i,
   // Debug and option inputs
   input  wire logic         debug_freeze_control_i,
   input  wire logic         core_halted_i,
   input  wire logic         hw_auto_start_i,
   // System outputs
   output logic              sys_reset_o,
   output logic              irq_o
);
   iwd_core_if cif ();

   iwd_core u_core (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cif   (cif)
   );

   logic                        ack_q;
   logic [31:0]                 dat_q;
   logic                        req;
   logic                        wr_en;
   logic                        key_wr;
   logic [15:0]                 key_val;
   logic [31:0]                 wr_word;
   logic                        unlock_q;
   logic [iwd_pkg::DIV_W-1:0]   div_q;
   logic [iwd_pkg::DIV_W-1:0]   div_eff_q;
   logic [iwd_pkg::RLD_W-1:0]   rld_q;
   logic [iwd_pkg::RLD_W-1:0]   rld_eff_q;
   logic [1:0]                  set_pend;
   logic [1:0]                  pend_q;
   logic [1:0]                  upd_done;
   logic [1:0]                  ucnt_q [2];
   logic                        osc_s1_q;
   logic                        osc_s2_q;
   logic                        osc_s3_q;
   logic                        osc_lvl_q;
   logic                        tick;
   logic                        boot_q;
   logic                        exp_q;
   logic [iwd_pkg::EVT_W-1:0]   evt_ev;
   logic [iwd_pkg::EVT_W-1:0]   evt_clr;
   logic [iwd_pkg::EVT_W-1:0]   evt_q;
   logic [iwd_pkg::EVT_W-1:0]   msk_q;

   // Bus decode. Ack comes one cycle after the request and drops the next cycle.
   assign req      = wb_cyc_i & wb_stb_i;
   assign wr_en    = req & wb_we_i & ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // A key needs both low byte lanes; anything narrower counts as another value.
   assign key_wr  = wr_en && (wb_adr_i == iwd_pkg::OFF_KEY);
   assign key_val = (wb_sel_i[1:0] == 2'b11) ? wb_dat_i[15:0] : 16'h0000; // see R11

   assign set_pend[iwd_pkg::UPD_DIV_BIT] = wr_en && unlock_q &&
                                           (wb_adr_i == iwd_pkg::OFF_DIV); // see R5
   assign set_pend[iwd_pkg::UPD_RLD_BIT] = wr_en && unlock_q &&
                                           (wb_adr_i == iwd_pkg::OFF_RLD); // see R5

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Write data merged into the addressed register by byte lanes.
   always_comb begin
      wr_word = '0;
      case (wb_adr_i)
         iwd_pkg::OFF_DIV: wr_word = iwd_pkg::iwd_merge({29'h0, div_q}, wb_dat_i, wb_sel_i);
         iwd_pkg::OFF_RLD: wr_word = iwd_pkg::iwd_merge({20'h0, rld_q}, wb_dat_i, wb_sel_i);
         iwd_pkg::OFF_MSK: wr_word = iwd_pkg::iwd_merge({29'h0, msk_q}, wb_dat_i, wb_sel_i);
         iwd_pkg::OFF_EVT: wr_word = iwd_pkg::iwd_merge(32'h0, wb_dat_i, wb_sel_i);
         default:          wr_word = '0;
      endcase
   end

   // Read data is captured with the ack. Divider and reload read the written value,
   // which is not yet in force while its pending flag stands.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= '0;
      end else if (req && !ack_q) begin
         case (wb_adr_i)
            iwd_pkg::OFF_DIV: dat_q <= {29'h0, div_q}; // see R6
            iwd_pkg::OFF_RLD: dat_q <= {20'h0, rld_q}; // see R7
            iwd_pkg::OFF_UPD: dat_q <= {30'h0, pend_q}; // see R6, R7
            iwd_pkg::OFF_EVT: dat_q <= {29'h0, evt_q};
            iwd_pkg::OFF_MSK: dat_q <= {29'h0, msk_q};
            iwd_pkg::OFF_CNT: dat_q <= {20'h0, cif.count};
            default:          dat_q <= '0;
         endcase
      end
   end

   // Write protection follows the last command written.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_q <= 1'b0;
      end else if (key_wr) begin
         unlock_q <= (key_val == iwd_pkg::KEY_UNLOCK); // see R1, R12
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= iwd_pkg::DIV_RST;
      end else if (set_pend[iwd_pkg::UPD_DIV_BIT]) begin
         div_q <= wr_word[iwd_pkg::DIV_W-1:0]; // see R4, R5
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rld_q <= iwd_pkg::RLD_RST; // see R8
      end else if (set_pend[iwd_pkg::UPD_RLD_BIT]) begin
         rld_q <= wr_word[iwd_pkg::RLD_W-1:0]; // see R5, R8
      end
   end

   // Oscillator pin: three flops, a rising level change counts once the last two agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_q  <= 1'b0;
         osc_s2_q  <= 1'b0;
         osc_s3_q  <= 1'b0;
         osc_lvl_q <= 1'b0;
      end else begin
         osc_s1_q <= low_speed_oscillator_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         if (osc_s2_q == osc_s3_q) begin
            osc_lvl_q <= osc_s3_q;
         end
      end
   end

   assign tick = (osc_s2_q == osc_s3_q) & osc_s3_q & ~osc_lvl_q;

   localparam logic [1:0] UPD_LAST = iwd_pkg::UPD_TICKS - 2'h1;

   // A new setting reaches the counter only after a few oscillator ticks, as the
   // slow domain would see it. A second write restarts the wait.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         upd_done[i] = pend_q[i] & tick & (ucnt_q[i] == UPD_LAST) & ~set_pend[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= '0;
         for (int i = 0; i < 2; i++) begin
            ucnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (set_pend[i]) begin
               pend_q[i] <= 1'b1; // see R6, R7
               ucnt_q[i] <= '0;
            end else if (upd_done[i]) begin
               pend_q[i] <= 1'b0; // see R6, R7
            end else if (pend_q[i] && tick) begin
               ucnt_q[i] <= ucnt_q[i] + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_eff_q <= iwd_pkg::DIV_RST;
         rld_eff_q <= iwd_pkg::RLD_RST;
      end else begin
         if (upd_done[iwd_pkg::UPD_DIV_BIT]) begin
            div_eff_q <= div_q;
         end
         if (upd_done[iwd_pkg::UPD_RLD_BIT]) begin
            rld_eff_q <= rld_q;
         end
      end
   end

   // The option input is looked at only in the first cycle after reset release.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_q <= 1'b0;
      end else begin
         boot_q <= 1'b1;
      end
   end

   assign cif.tick    = tick;
   assign cif.start   = (key_wr && key_val == iwd_pkg::KEY_START) ||
                        (!boot_q && hw_auto_start_i); // see R2, R15
   assign cif.reload  = key_wr && (key_val == iwd_pkg::KEY_RELOAD); // see R3
   assign cif.freeze  = debug_freeze_control_i & core_halted_i; // see R14
   assign cif.div_sel = div_eff_q;
   assign cif.rld_val = rld_eff_q;

   // Sticky events; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exp_q <= 1'b0;
      end else begin
         exp_q <= cif.expired;
      end
   end

   assign evt_ev[iwd_pkg::EVT_EXP_BIT] = cif.expired & ~exp_q;
   assign evt_ev[iwd_pkg::EVT_DIV_BIT] = upd_done[iwd_pkg::UPD_DIV_BIT];
   assign evt_ev[iwd_pkg::EVT_RLD_BIT] = upd_done[iwd_pkg::UPD_RLD_BIT];
   assign evt_clr = (wr_en && wb_adr_i == iwd_pkg::OFF_EVT) ?
                    wr_word[iwd_pkg::EVT_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_q <= iwd_pkg::EVT_RST;
      end else begin
         evt_q <= (evt_q & ~evt_clr) | evt_ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msk_q <= iwd_pkg::MSK_RST;
      end else if (wr_en && wb_adr_i == iwd_pkg::OFF_MSK) begin
         msk_q <= wr_word[iwd_pkg::EVT_W-1:0];
      end
   end

   assign irq_o       = |(evt_q & msk_q);
   assign sys_reset_o = cif.expired; // see R2

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_unlock_key: assert property (key_wr && key_val == iwd_pkg::KEY_UNLOCK |=> unlock_q) // see R1
      else $error("Unlock key did not lift protection");

   a_relock_key: assert property (key_wr && key_val != iwd_pkg::KEY_UNLOCK // see R12
                                  |=> !unlock_q)
      else $error("Other key left protection lifted");

   a_start_key: assert property (key_wr && key_val == iwd_pkg::KEY_START && !cif.expired // see R2
                                 |=> cif.running)
      else $error("Start key did not start the counter");

   a_locked_div: assert property (wr_en && !unlock_q // see R5
                                  |=> $stable(div_q) && $stable(rld_q))
      else $error("Locked write changed a protected register");

   a_div_pend: assert property (set_pend[iwd_pkg::UPD_DIV_BIT] // see R6
                                |=> pend_q[iwd_pkg::UPD_DIV_BIT] [*2])
      else $error("Divider pending flag not raised");

   a_rld_pend: assert property (set_pend[iwd_pkg::UPD_RLD_BIT] // see R7
                                |=> pend_q[iwd_pkg::UPD_RLD_BIT]
                                    && rld_q == $past(wr_word[11:0]))
      else $error("Reload pending flag or value wrong");

   a_pend_clear: assert property ($fell(pend_q[iwd_pkg::UPD_RLD_BIT]) // see R7
                                  |-> rld_eff_q == rld_q)
      else $error("Reload cleared pending without taking the value");

   a_reload_rst: assert property ($fell(rst_i) |-> rld_q == iwd_pkg::RLD_RST) // see R8
      else $error("Reload register reset value wrong");

   a_no_stop: assert property (cif.running |=> cif.running || cif.expired) // see R16
      else $error("Running counter stopped");

   a_auto_start: assert property (@(posedge clk_i) $fell(rst_i) && hw_auto_start_i // see R15
                                  |=> cif.running)
      else $error("Auto start did not start the counter");

   // The checks below pin down what may move the counter and drop the update flags, so a
   // counter move without a tick or a command, or a flag drop without a tick, shows up as a failure at once.
   a_count_step: assert property (!tick && !cif.reload && !cif.start // see R13
                                  |=> $stable(cif.count))
      else $error("Counter moved without a tick or a command");

   a_start_load: assert property (cif.start && !cif.running && !cif.expired // see R2
                                  |=> cif.count == $past(rld_eff_q))
      else $error("Start did not load the reload value in force");

   a_div_apply: assert property (upd_done[iwd_pkg::UPD_DIV_BIT] // see R6
                                 |=> div_eff_q == $past(div_q))
      else $error("Divider update did not reach the counter");

   a_div_wait: assert property (pend_q[iwd_pkg::UPD_DIV_BIT] && !tick // see R6
                                |=> pend_q[iwd_pkg::UPD_DIV_BIT])
      else $error("Divider pending flag fell without a tick");

   a_rld_wait: assert property (pend_q[iwd_pkg::UPD_RLD_BIT] && !tick // see R7
                                |=> pend_q[iwd_pkg::UPD_RLD_BIT])
      else $error("Reload pending flag fell without a tick");

   a_exp_event: assert property ($rose(sys_reset_o) |=> evt_q[iwd_pkg::EVT_EXP_BIT]) // see R2
      else $error("Expiry did not set its event bit");

   a_reset_hold: assert property (sys_reset_o |=> sys_reset_o) // see R2, R16
      else $error("System reset fell without a device reset");

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // see R11
      else $error("Ack stood longer than one cycle");

   c_unlock_write: cover property (key_wr && key_val == iwd_pkg::KEY_UNLOCK ##[1:20]
                                   set_pend[iwd_pkg::UPD_DIV_BIT]);
   c_reload_run: cover property (cif.running && cif.reload);
   c_pend_done: cover property (upd_done[iwd_pkg::UPD_RLD_BIT]);
   c_irq: cover property ($rose(irq_o));
endmodule : iwd_regs

// ---- bench/test_iwd_regs.sv ----
// Self-checking testbench of the independent watchdog register block.
`timescale 1ns/1ps
module test_iwd_regs;
   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [4:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        osc;
   logic        dbg_hold;
   logic        halted;
   logic        auto_start;
   logic        sys_reset_o;
   logic        irq_o;
   logic [31:0] rd;
   int          n_fail;
   int          check_count;
   int          cyc_cnt;

   iwd_regs i_dut (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .wb_cyc_i               (wb_cyc_i),
      .wb_stb_i               (wb_stb_i),
      .wb_we_i                (wb_we_i),
      .wb_adr_i               (wb_adr_i),
      .wb_sel_i               (wb_sel_i),
      .wb_dat_i               (wb_dat_i),
      .wb_dat_o               (wb_dat_o),
      .wb_ack_o               (wb_ack_o),
      .low_speed_oscillator_i (osc),
      .debug_freeze_control_i (dbg_hold),
      .core_halted_i          (halted),
      .hw_auto_start_i        (auto_start),
      .sys_reset_o            (sys_reset_o),
      .irq_o                  (irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   // The ceiling leaves ample room over the roughly 19000 cycles the tests need.
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 60000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One classic cycle; the leading edge keeps the bus idle for a cycle between requests.
   task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat, 4'hF);
   endtask : wr

   task automatic rdr(input logic [4:0] adr);
      wb(1'b0, adr, 32'h0000_0000, 4'hF);
   endtask : rdr

   task automatic rd_chk(input logic [4:0] adr, input logic [31:0] exp);
      rdr(adr);
      check(rd, exp);
   endtask : rd_chk

   // Oscillator ticks are slow against the bus clock so the synchroniser settles.
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         osc <= 1'b1;
         repeat (4) @(posedge clk_i);
         osc <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask : tick

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         tick(1);
         rdr(iwd_pkg::OFF_UPD);
         k++;
      end while (rd[1:0] !== 2'b00 && k < 10);
      check(32'(k), 32'h0000_0003);
   endtask : wait_idle

   // Skips the first decrement, whose prescaler phase is unknown, then times the next.
   task automatic measure(input int exp_ticks);
      int          k;
      logic [11:0] a;
      for (int p = 0; p < 2; p++) begin
         rdr(iwd_pkg::OFF_CNT);
         a = rd[11:0];
         k = 0;
         while (rd[11:0] === a && k < 600) begin
            tick(1);
            rdr(iwd_pkg::OFF_CNT);
            k++;
         end
      end
      check(32'(k), 32'(exp_ticks));
   endtask : measure

   logic [4:0]  adr_tab [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
   logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'hFFF, 32'h0, 32'h0, 32'h0, 32'hFFF, 32'h0};

   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 5'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      osc = 1'b0;
      dbg_hold = 1'b0;
      halted = 1'b0;
      auto_start = 1'b0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_chk(adr_tab[i], rst_tab[i]);
      end
      wr(iwd_pkg::OFF_RLD, 32'h0000_0123);
      rd_chk(iwd_pkg::OFF_RLD, 32'h0000_0FFF);
      wb(1'b1, iwd_pkg::OFF_KEY, 32'h0000_5555, 4'h3);
      wb(1'b1, iwd_pkg::OFF_RLD, 32'h0000_07FF, 4'h3);
      rd_chk(iwd_pkg::OFF_UPD, 32'h0000_0002);
      wait_idle();
      rd_chk(iwd_pkg::OFF_EVT, 32'h0000_0004);
      wr(iwd_pkg::OFF_MSK, 32'h0000_0007);
      @(posedge clk_i);
      check(32'(irq_o), 32'h0000_0001);
      wr(iwd_pkg::OFF_EVT, 32'h0000_0004);
      @(posedge clk_i);
      check(32'(irq_o), 32'h0000_0000);
      wr(iwd_pkg::OFF_KEY, 32'h0000_1234);
      wr(iwd_pkg::OFF_RLD, 32'h0000_0001);
      rd_chk(iwd_pkg::OFF_RLD, 32'h0000_07FF);
      wr(iwd_pkg::OFF_KEY, 32'h0000_CCCC);
      // Each divider code is timed with the write lock restored, which must not stop the count.
      for (int c = 0; c < 8; c++) begin
         wr(iwd_pkg::OFF_KEY, 32'h0000_5555);
         wr(iwd_pkg::OFF_DIV, 32'(c));
         rd_chk(iwd_pkg::OFF_UPD, 32'h0000_0001);
         wr(iwd_pkg::OFF_KEY, 32'h0000_0000);
         wait_idle();
         measure((c > 5) ? 256 : (4 << c));
      end
      wr(iwd_pkg::OFF_KEY, 32'h0000_AAAA);
      rd_chk(iwd_pkg::OFF_CNT, 32'h0000_07FF);
      wr(iwd_pkg::OFF_KEY, 32'h0000_5555);
      wr(iwd_pkg::OFF_DIV, 32'h0000_0000);
      wr(iwd_pkg::OFF_RLD, 32'h0000_0002);
      wait_idle();
      wr(iwd_pkg::OFF_EVT, 32'h0000_0006);
      @(posedge clk_i);
      check(32'(irq_o), 32'h0000_0000);
      dbg_hold <= 1'b1;
      halted <= 1'b1;
      wr(iwd_pkg::OFF_KEY, 32'h0000_AAAA);
      tick(20);
      rd_chk(iwd_pkg::OFF_CNT, 32'h0000_0002);
      check(32'(sys_reset_o), 32'h0000_0000);
      halted <= 1'b0;
      tick(16);
      check(32'(sys_reset_o), 32'h0000_0001);
      rd_chk(iwd_pkg::OFF_CNT, 32'h0000_0000);
      rdr(iwd_pkg::OFF_EVT);
      check(32'(rd[0]), 32'h0000_0001);
      check(32'(irq_o), 32'h0000_0001);
      // A second reset with the option bit set must start the count without a key.
      dbg_hold <= 1'b0;
      rst_i <= 1'b1;
      auto_start <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      auto_start <= 1'b0;
      check(32'(sys_reset_o), 32'h0000_0000);
      tick(8);
      rdr(iwd_pkg::OFF_CNT);
      check(32'(rd[11:0]), 32'h0000_0FFD);
      complete_run();
   end
endmodule : test_iwd_regs
